// File: buck_seq_pkg.sv
// Constants and carrier types for the buck configuration and protection sequencer
package buck_seq_pkg;

    // Interface register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h0c;
    localparam logic [7:0] OFS_CONFIG  = 8'h10;

    // Control field positions
    localparam int CTRL_FORCE_OFF_BIT = 0;

    // Interrupt status bit positions
    localparam int IRQ_OC_BIT      = 0;
    localparam int IRQ_HICCUP_BIT  = 1;
    localparam int IRQ_RESTART_BIT = 2;
    localparam int IRQ_SKIP_BIT    = 3;
    localparam int IRQ_W           = 4;

    // Feedback strap codes from the pull-up detector
    localparam logic [1:0] FB_STRAP_TIE  = 2'h0;
    localparam logic [1:0] FB_STRAP_R249 = 2'h1;
    localparam logic [1:0] FB_STRAP_R499 = 2'h2;
    localparam logic [1:0] FB_STRAP_NONE = 2'h3;

    // Configuration strap codes from the resistor detector
    localparam logic [2:0] CFG_R299 = 3'h0;
    localparam logic [2:0] CFG_R412 = 3'h1;
    localparam logic [2:0] CFG_R549 = 3'h2;
    localparam logic [2:0] CFG_R715 = 3'h3;
    localparam logic [2:0] CFG_R909 = 3'h4;

    // Output voltage selections
    typedef enum logic [1:0] {
        VSEL_3V3 = 2'b00,
        VSEL_5V  = 2'b01,
        VSEL_12V = 2'b10,
        VSEL_EXT = 2'b11
    } vsel_t;

    // Protection state machine
    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_SOFT   = 3'b001,
        ST_RUN    = 3'b010,
        ST_HICCUP = 3'b011
    } pstate_t;

    // Timing constants
    localparam int CLK_MHZ          = 200;
    localparam int SOFT_START_US    = 3000;
    localparam int SOFT_START_CYC   = SOFT_START_US * CLK_MHZ;
    localparam int TON_MIN_NS       = 50;
    localparam int TON_MIN_CYC      = (TON_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int OVL_LIMIT        = 512;
    localparam int OK_RUN_LIMIT     = 4;
    localparam int OFF_TIME_CYCLES  = 16384;
    localparam int CLAMP_OC_EVENTS  = 16;
    localparam logic [15:0] CLAMP_MV = 16'h0096; // 150 mV above feedback

    // Latched configuration
    typedef struct packed {
        vsel_t vsel;
        logic  comp_internal;
        logic  spread_strap;
        logic  primary;
    } strap_cfg_t;

    // Gate drive pair
    typedef struct packed {
        logic high_side_drive;
        logic low_side_drive;
    } drive_t;

endpackage

// File: buck_seq.sv
// Strap latching, spreading, soft start, current limit and hiccup sequencer
// What this block does
// - Spreading applies slow triangle plus fresh random offset every switching cycle
// - Spreading allowed only for the two spreading configuration straps
// - External clock on skip_sync_input forces spreading off
// - Soft-start reference ramps over nominal 3 ms from switching start
// - Feedback strap selects 3.3 V, 5 V, 12 V or external divider
// - Output-voltage choice latched until bias undervoltage then recovery
// - On-time below 50 ns demand makes the device skip pulses
// - Compensation pull-up detected selects internal, else external; latched
// - Compensation choice re-evaluated only after bias undervoltage
// - Sense above 60 mV ends the high-side pulse immediately
// - After sixteen overcurrent events clamp soft start 150 mV above feedback
// - Overload counts 512 cycles of current limiting before hiccup
// - Four clean cycles in a row clear the overload counter
// - Counter expiry: soft start low, drives off, off-time count starts
// - Off-time reaching 16384 cycles restarts through normal soft start
// - Hiccup protection held off during soft start until feedback above 0.4 V
// - Soft start begins only with bias good and enable high
// - Primary with spreading does not follow external synchronization clocks
`timescale 1ns/100ps
module buck_seq
    import buck_seq_pkg::*;
#(
    parameter int SS_CYCLES  = SOFT_START_CYC,
    parameter int OFF_CYCLES = OFF_TIME_CYCLES,
    parameter int DITHER_W   = 8
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        sw_tick,
    input  wire logic        enable_in,
    input  wire logic [1:0]  feedback_strap,
    input  wire logic        comp_pullup_det,
    input  wire logic [2:0]  config_select_strap,
    input  wire logic        skip_sync_input,
    input  wire logic        ext_clk_present,
    input  wire logic        fb_above_0v4,
    input  wire logic        current_limit_trip,
    input  wire logic        pwm_on_req,
    input  wire logic [7:0]  ton_demand_cyc,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    output drive_t           gate,
    output logic             ss_pull_low,
    output logic             ss_clamp_en,
    output logic      [15:0] ss_clamp_mv,
    output logic      [15:0] ss_ref,
    output logic             pulse_skip,
    output logic             spread_active,
    output logic signed [DITHER_W-1:0] freq_offset,
    output strap_cfg_t       cfg,
    output logic             irq
);

    localparam int SSW  = $clog2(SS_CYCLES + 1);
    localparam int OFFW = $clog2(OFF_CYCLES + 1);

    // Strap capture and configuration state
    logic        latched_q;
    strap_cfg_t  cfg_q;
    pstate_t     st_q;
    pstate_t     st_d;
    logic [SSW-1:0]  ss_cnt_q;
    logic [OFFW-1:0] off_cnt_q;
    logic [9:0]  ovl_cnt_q;
    logic [2:0]  ok_cnt_q;
    logic [4:0]  oc_evt_q;
    logic        cyc_trip_q;
    logic        hs_q;
    logic        ls_q;
    logic [DITHER_W-1:0] tri_q;
    logic        tri_up_q;
    logic [15:0] lfsr_q;
    logic [DITHER_W-1:0] rnd_q;
    logic        force_off_q;
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_msk_q;
    logic [31:0] rdata_q;

    // Decode of the straps before latching
    vsel_t fb_vsel;
    assign fb_vsel = (feedback_strap == FB_STRAP_TIE)  ? VSEL_3V3 :
                     (feedback_strap == FB_STRAP_R249) ? VSEL_5V  :
                     (feedback_strap == FB_STRAP_R499) ? VSEL_12V : VSEL_EXT;
    wire spread_strap = (config_select_strap == CFG_R412)
                     || (config_select_strap == CFG_R715);
    wire primary_strap = (config_select_strap != CFG_R909);

    // Straps caught once after bias reset release; only a new bias reset reopens them
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latched_q <= 1'b0;
            cfg_q     <= '0;
        end else if (!latched_q) begin
            latched_q <= 1'b1;
            cfg_q     <= '{vsel: fb_vsel, comp_internal: comp_pullup_det,
                           spread_strap: spread_strap, primary: primary_strap};
        end
    end
    assign cfg = cfg_q;

    // Spreading allowed by strap and killed by any external clock, whatever the strap
    wire sync_locked  = ext_clk_present && skip_sync_input;
    wire ignore_sync  = cfg_q.primary && cfg_q.spread_strap;
    // Primary spreading parts never follow the pin; they stay on their own oscillator
    wire sync_follow  = latched_q && sync_locked && !ignore_sync;
    assign spread_active = latched_q && cfg_q.spread_strap && !sync_locked;

    // Triangle sweep plus a fresh random step, both moved once per switching cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tri_q    <= '0;
            tri_up_q <= 1'b1;
            lfsr_q   <= 16'hace1;
            rnd_q    <= '0;
        end else if (sw_tick && spread_active) begin
            tri_q    <= tri_up_q ? tri_q + 1'b1 : tri_q - 1'b1;
            if (tri_up_q && (tri_q == {DITHER_W{1'b1}} - 1'b1))
                tri_up_q <= 1'b0;
            else if (!tri_up_q && (tri_q == {{(DITHER_W-1){1'b0}}, 1'b1}))
                tri_up_q <= 1'b1;
            lfsr_q   <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            rnd_q    <= lfsr_q[DITHER_W-1:0];
        end
    end
    // Random part kept at a quarter of the span so the triangle dominates
    wire signed [DITHER_W-1:0] tri_s = $signed(tri_q ^ {1'b1, {(DITHER_W-1){1'b0}}});
    wire signed [DITHER_W-1:0] rnd_s = $signed(rnd_q) >>> 2;
    assign freq_offset = spread_active ? (tri_s >>> 1) + rnd_s : '0;

    // Protection sequencing
    wire start_ok     = latched_q && enable_in && !force_off_q;
    wire hiccup_arm   = (st_q == ST_RUN) || ((st_q == ST_SOFT) && fb_above_0v4);
    wire ovl_expire   = hiccup_arm && (ovl_cnt_q == 10'(OVL_LIMIT - 1))
                        && sw_tick && (cyc_trip_q || current_limit_trip);
    wire ss_done      = (ss_cnt_q == SSW'(SS_CYCLES));
    wire off_done     = (off_cnt_q == OFFW'(OFF_CYCLES - 1)) && sw_tick;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_OFF:    if (start_ok) st_d = ST_SOFT;
            ST_SOFT:   if (!start_ok) st_d = ST_OFF;
                       else if (ovl_expire) st_d = ST_HICCUP;
                       else if (ss_done) st_d = ST_RUN;
            ST_RUN:    if (!start_ok) st_d = ST_OFF;
                       else if (ovl_expire) st_d = ST_HICCUP;
            ST_HICCUP: if (!start_ok) st_d = ST_OFF;
                       else if (off_done) st_d = ST_SOFT;
            default:   st_d = ST_OFF;
        endcase
    end

    // State and soft-start ramp timer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q     <= ST_OFF;
            ss_cnt_q <= '0;
        end else begin
            st_q     <= st_d;
            if (st_d != ST_SOFT && st_d != ST_RUN)
                ss_cnt_q <= '0;
            else if (!ss_done)
                ss_cnt_q <= ss_cnt_q + 1'b1;
        end
    end
    // Reference as a fraction of full scale, 16 bits
    // Product kept at 48 bits: the default ramp length times full scale overflows 32
    assign ss_ref      = 16'((48'(ss_cnt_q) * 48'hffff) / 48'(SS_CYCLES));
    assign ss_pull_low = (st_q == ST_OFF) || (st_q == ST_HICCUP);

    // Hiccup off-time counter in switching cycles
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            off_cnt_q <= '0;
        else if (st_q != ST_HICCUP)
            off_cnt_q <= '0;
        else if (sw_tick)
            off_cnt_q <= off_cnt_q + 1'b1;
    end

    // Per-cycle trip memory, overload count, clean-run count, event count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_trip_q <= 1'b0;
            ovl_cnt_q  <= '0;
            ok_cnt_q   <= '0;
            oc_evt_q   <= '0;
        end else if (!hiccup_arm) begin
            cyc_trip_q <= 1'b0;
            ovl_cnt_q  <= '0;
            ok_cnt_q   <= '0;
            oc_evt_q   <= '0;
        end else if (sw_tick) begin
            cyc_trip_q <= 1'b0;
            if (cyc_trip_q || current_limit_trip) begin
                ok_cnt_q  <= '0;
                ovl_cnt_q <= ovl_expire ? '0 : ovl_cnt_q + 1'b1;
                if (oc_evt_q != 5'(CLAMP_OC_EVENTS))
                    oc_evt_q <= oc_evt_q + 1'b1;
            end else if (ok_cnt_q == 3'(OK_RUN_LIMIT - 1)) begin
                ok_cnt_q  <= '0;
                ovl_cnt_q <= '0;
                oc_evt_q  <= '0;
            end else begin
                ok_cnt_q  <= ok_cnt_q + 1'b1;
            end
        end else if (current_limit_trip) begin
            cyc_trip_q <= 1'b1;
        end
    end
    assign ss_clamp_en = (oc_evt_q == 5'(CLAMP_OC_EVENTS)) && cyc_trip_q;
    assign ss_clamp_mv = CLAMP_MV;

    // Minimum on-time check: too short a demand skips the pulse
    assign pulse_skip = pwm_on_req && (ton_demand_cyc < 8'(TON_MIN_CYC));

    // Gate drives; trip gates the high side combinationally, never both on
    wire drive_ok = (st_q == ST_SOFT) || (st_q == ST_RUN);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_q <= 1'b0;
            ls_q <= 1'b0;
        end else begin
            hs_q <= drive_ok && pwm_on_req && !pulse_skip;
            ls_q <= drive_ok && !(pwm_on_req && !pulse_skip);
        end
    end
    assign gate.high_side_drive = hs_q && !current_limit_trip && !cyc_trip_q
                                  && drive_ok;
    assign gate.low_side_drive  = ls_q && !gate.high_side_drive && drive_ok;

    // Sticky events: set wins over write-one-to-clear
    wire [IRQ_W-1:0] irq_evt;
    assign irq_evt[IRQ_OC_BIT]      = current_limit_trip && hiccup_arm;
    assign irq_evt[IRQ_HICCUP_BIT]  = ovl_expire;
    assign irq_evt[IRQ_RESTART_BIT] = off_done && (st_q == ST_HICCUP);
    assign irq_evt[IRQ_SKIP_BIT]    = pulse_skip;

    // Register decode
    wire sel_ctrl = (addr == OFS_CTRL);
    wire sel_stat = (addr == OFS_STATUS);
    wire sel_ist  = (addr == OFS_IRQ_ST);
    wire sel_msk  = (addr == OFS_IRQ_MSK);
    wire sel_cfg  = (addr == OFS_CONFIG);
    wire [IRQ_W-1:0] w1c = (wr_en && sel_ist) ? wdata[IRQ_W-1:0] : '0;
    // Bit 13 shows the oscillator following the pin clock
    wire [31:0] status_word = {18'h0, sync_follow, oc_evt_q, ss_clamp_en, spread_active,
                               pulse_skip, latched_q, st_q, ss_pull_low};
    wire [31:0] rd_mux = sel_ctrl ? {31'h0, force_off_q} :
                         sel_stat ? status_word :
                         sel_ist  ? {28'h0, irq_st_q} :
                         sel_msk  ? {28'h0, irq_msk_q} :
                         sel_cfg  ? {27'h0, cfg_q} : 32'h0;

    // Registers written by software and read-data stage
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            force_off_q <= 1'b0;
            irq_msk_q   <= '0;
            irq_st_q    <= '0;
            rdata_q     <= '0;
        end else begin
            if (wr_en && sel_ctrl)
                force_off_q <= wdata[CTRL_FORCE_OFF_BIT];
            if (wr_en && sel_msk)
                irq_msk_q <= wdata[IRQ_W-1:0];
            irq_st_q <= (irq_st_q & ~w1c) | irq_evt;
            rdata_q  <= rd_en ? rd_mux : 32'h0;
        end
    end
    assign rdata = rdata_q;
    assign irq   = |(irq_st_q & irq_msk_q);

    // Checks beside the logic
    sequence s_trip_cycle;
        current_limit_trip;
    endsequence
    sequence s_hiccup_entry;
        (st_q == ST_RUN) ##1 (st_q == ST_HICCUP);
    endsequence

    hs_cut_by_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_trip_cycle |-> !gate.high_side_drive)
        else $error("high side on during current limit trip");
    spread_strap_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        spread_active |-> (cfg_q.spread_strap && latched_q))
        else $error("spreading without a spreading strap");
    hiccup_drives_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_hiccup_entry |-> (ss_pull_low && !gate.high_side_drive && !gate.low_side_drive))
        else $error("drives active in hiccup");
    hiccup_needs_arm_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ((st_q == ST_SOFT) && !fb_above_0v4) |=> (st_q != ST_HICCUP))
        else $error("hiccup entered before feedback reached 0.4 V");
    config_held_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        latched_q |=> $stable(cfg_q))
        else $error("latched configuration changed");
    clean_run_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sw_tick && hiccup_arm && !cyc_trip_q && !current_limit_trip
         && ok_cnt_q == 3'(OK_RUN_LIMIT - 1)) |=> (ovl_cnt_q == 10'h0))
        else $error("overload count survived four clean cycles");
    restart_soft_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ((st_q == ST_HICCUP) && off_done && start_ok) |=> (st_q == ST_SOFT))
        else $error("no restart after off time");
    clamp_needs_16_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ss_clamp_en |-> (oc_evt_q == 5'h10))
        else $error("clamp before sixteen events");
    start_needs_en_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ((st_q == ST_OFF) && !enable_in) |=> (st_q == ST_OFF))
        else $error("soft start without enable");
    skip_short_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pwm_on_req && ton_demand_cyc < 8'h0a) |-> pulse_skip)
        else $error("short on-time not skipped");

    // Spreading, ramp, strap capture and counter checks
    sequence s_spread_step;
        sw_tick && spread_active;
    endsequence

    // External clock wins over any strap
    sync_kills_spread_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        sync_locked |-> !spread_active)
        else $error("spreading with an external clock");
    // Generator never sticks, so every period gets a new random step
    random_step_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_spread_step |=> !$stable(lfsr_q))
        else $error("no fresh random step in a switching cycle");
    // Run only once the reference has reached full scale
    ramp_full_run_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (st_q == ST_RUN) |-> ss_done)
        else $error("run entered before the ramp finished");
    // Compensation choice taken from the pin at the capture edge
    comp_latch_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !latched_q |=> (cfg_q.comp_internal == $past(comp_pullup_det)))
        else $error("compensation choice not captured");
    // Expired overload count leads straight to the off time
    overload_hiccup_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ((st_q == ST_RUN) && ovl_expire && start_ok) |=> (st_q == ST_HICCUP))
        else $error("no hiccup after the overload count");
    // Off time counts switching periods, not core cycles
    off_count_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!sw_tick && (st_q == ST_HICCUP)) |=> $stable(off_cnt_q))
        else $error("off-time count moved between switching cycles");
    // A skipped pulse leaves the high side off
    skip_blocks_hs_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        pulse_skip |=> !gate.high_side_drive)
        else $error("high side driven for a skipped pulse");

endmodule

// File: power_stage_model.sv
// Behavioural power stage: current-sense and feedback comparators
`timescale 1ns/100ps
module power_stage_model
    import buck_seq_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_b,
    input  wire drive_t gate,
    input  wire logic   short_out,
    input  wire logic   out_up,
    output logic        current_limit_trip,
    output logic        fb_above_0v4
);
    // Sense comparator is instant: a lagging trip would leak into the next period
    assign current_limit_trip = short_out & rst_b;

    // Feedback rises a clock after a switch conducts, then holds while the output is up
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fb_above_0v4 <= 1'b0;
        end else begin
            fb_above_0v4 <= out_up & (fb_above_0v4 | (gate != 2'b00));
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the buck configuration and protection sequencer
`timescale 1ns/100ps
module testbench;
    import buck_seq_pkg::*;
    localparam int SS_N  = 4000;
    localparam int OFF_N = 16;
    logic               core_clk, rst_b, sw_tick, enable_in, comp_pullup_det;
    logic               skip_sync_input, ext_clk_present, fb_above_0v4, current_limit_trip;
    logic               pwm_on_req, wr_en, rd_en, short_out, out_up;
    logic               ss_pull_low, ss_clamp_en, pulse_skip, spread_active, irq;
    logic        [1:0]  feedback_strap;
    logic        [2:0]  config_select_strap;
    logic        [7:0]  ton_demand_cyc, addr;
    logic        [31:0] wdata, rdata;
    logic        [15:0] ss_clamp_mv, ss_ref;
    logic signed [7:0]  freq_offset;
    drive_t             gate;
    strap_cfg_t         cfg;
    int                 failures, n_tests;
    vsel_t              vs_exp [4] = '{VSEL_3V3, VSEL_5V, VSEL_12V, VSEL_EXT};

    buck_seq #(.SS_CYCLES(SS_N), .OFF_CYCLES(OFF_N)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .sw_tick(sw_tick), .enable_in(enable_in),
        .feedback_strap(feedback_strap), .comp_pullup_det(comp_pullup_det),
        .config_select_strap(config_select_strap), .skip_sync_input(skip_sync_input),
        .ext_clk_present(ext_clk_present), .fb_above_0v4(fb_above_0v4),
        .current_limit_trip(current_limit_trip), .pwm_on_req(pwm_on_req),
        .ton_demand_cyc(ton_demand_cyc), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .gate(gate), .ss_pull_low(ss_pull_low),
        .ss_clamp_en(ss_clamp_en), .ss_clamp_mv(ss_clamp_mv), .ss_ref(ss_ref),
        .pulse_skip(pulse_skip), .spread_active(spread_active),
        .freq_offset(freq_offset), .cfg(cfg), .irq(irq));

    power_stage_model stage_u (
        .core_clk(core_clk), .rst_b(rst_b), .gate(gate), .short_out(short_out),
        .out_up(out_up), .current_limit_trip(current_limit_trip),
        .fb_above_0v4(fb_above_0v4));

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk_state(input pstate_t s);
        logic [31:0] d;
        rd(OFS_STATUS, d);
        chk({29'h0, d[3:1]}, {29'h0, s});
    endtask

    // Switching periods of three cycles; trip level held for the whole period
    task automatic tick(input logic t, input int n);
        repeat (n) begin
            @(posedge core_clk);
            short_out <= t;
            sw_tick   <= 1'b0;
            repeat (2) @(posedge core_clk);
            sw_tick <= 1'b1;
        end
        @(posedge core_clk);
        sw_tick <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    // Straps settle while reset holds, as the bias rail would come up
    task automatic do_reset(input logic [2:0] c, input logic [1:0] f, input logic p);
        @(posedge core_clk);
        rst_b               <= 1'b0;
        config_select_strap <= c;
        feedback_strap      <= f;
        comp_pullup_det     <= p;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // Cut a hang short well past the expected run length
    initial begin
        #500000;
        failures++;
        summarize();
    end

    initial begin
        int               i;
        int               chg;
        logic [31:0]      d;
        logic signed [7:0] o;
        rst_b <= 1'b0; sw_tick <= 1'b0; enable_in <= 1'b0; comp_pullup_det <= 1'b0;
        feedback_strap <= 2'h0; config_select_strap <= 3'h0; skip_sync_input <= 1'b0;
        ext_clk_present <= 1'b0; pwm_on_req <= 1'b0; ton_demand_cyc <= 8'h40;
        addr <= 8'h00; wdata <= 32'h0; wr_en <= 1'b0; rd_en <= 1'b0;
        short_out <= 1'b0; out_up <= 1'b0;
        failures = 0;
        n_tests  = 0;
        // Every strap code decoded and latched
        for (i = 0; i < 5; i++) begin
            do_reset(i[2:0], i[1:0], i[0]);
            chk(cfg.vsel, vs_exp[i % 4]);
            chk(cfg.spread_strap, (i == 1 || i == 3));
            chk(cfg.comp_internal, i[0]);
            chk(cfg.primary, (i != 4));
            chk({ss_pull_low, gate, irq}, 4'h8);
        end
        feedback_strap  <= 2'h2;
        comp_pullup_det <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        chk({cfg.vsel, cfg.comp_internal}, {VSEL_3V3, 1'b0});
        chk_state(ST_OFF);
        rd(8'h20, d);
        chk(d, 32'h0);
        // Start with the output shorted and feedback low
        do_reset(CFG_R412, FB_STRAP_NONE, 1'b0);
        enable_in <= 1'b1;
        tick(1'b1, 520);
        chk_state(ST_SOFT);
        chk({ss_pull_low, ss_ref != 16'h0}, 2'b01);
        out_up <= 1'b1;
        pwm_on_req <= 1'b1;
        tick(1'b0, SS_N);
        chk_state(ST_RUN);
        chk(ss_ref, 32'h0000ffff);
        // Spreading: fresh offset each period, off with an external clock
        chk(spread_active, 1'b1);
        chg = 0;
        for (i = 0; i < 8; i++) begin
            o = freq_offset;
            tick(1'b0, 1);
            chg += (o !== freq_offset);
        end
        chk(chg >= 6, 1'b1);
        skip_sync_input <= 1'b1;
        ext_clk_present <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk(spread_active, 1'b0);
        rd(OFS_STATUS, d);
        chk(d[13], 1'b0);
        skip_sync_input <= 1'b0;
        ext_clk_present <= 1'b0;
        // Minimum on-time boundary
        ton_demand_cyc <= 8'h09;
        repeat (2) @(posedge core_clk);
        #1 chk(pulse_skip, 1'b1);
        ton_demand_cyc <= 8'h0a;
        repeat (2) @(posedge core_clk);
        #1 chk(pulse_skip, 1'b0);
        ton_demand_cyc <= 8'h40;
        // High side ends in the cycle of the trip
        repeat (4) @(posedge core_clk);
        #1 chk(gate.high_side_drive, 1'b1);
        short_out <= 1'b1;
        @(posedge core_clk);
        #1 chk(gate.high_side_drive, 1'b0);
        short_out <= 1'b0;
        tick(1'b0, 5);
        tick(1'b1, 15);
        chk(ss_clamp_en, 1'b0);
        tick(1'b1, 1);
        chk({ss_clamp_en, ss_clamp_mv}, {1'b1, CLAMP_MV});
        tick(1'b0, 5);
        tick(1'b1, 511);
        chk_state(ST_RUN);
        tick(1'b1, 1);
        chk({ss_pull_low, gate}, 3'h4);
        short_out <= 1'b0;
        chk_state(ST_HICCUP);
        // Mask bits enable: interrupt held off, let through, then cleared
        wr(OFS_IRQ_MSK, 32'h0);
        repeat (2) @(posedge core_clk);
        #1 chk(irq, 1'b0);
        wr(OFS_IRQ_MSK, 32'h0000000f);
        rd(OFS_IRQ_ST, d);
        chk(d[IRQ_HICCUP_BIT], 1'b1);
        chk(irq, 1'b1);
        wr(OFS_IRQ_ST, 32'h0000000f);
        rd(OFS_IRQ_ST, d);
        chk({d, irq}, 33'h0);
        tick(1'b0, OFF_N - 1);
        chk_state(ST_HICCUP);
        tick(1'b0, 1);
        chk_state(ST_SOFT);
        chk(ss_pull_low, 1'b0);
        // Software off and the latched configuration word
        wr(OFS_CTRL, 32'h00000001);
        rd(OFS_CTRL, d);
        chk(d, 32'h00000001);
        chk_state(ST_OFF);
        rd(OFS_CONFIG, d);
        chk(d, 32'h0000001b);
        summarize();
    end
endmodule
